/* verilog/serial_port_pkg.sv */
// Purpose: shared constants for the three-wire serial register port
// Assumes: byte-wide registers, 7-bit register address
// Notes: link pins are sampled by the 125 MHz system clock
package serial_port_pkg;

    // ******************************************************************
    // widths and counts
    // ******************************************************************
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 128;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_RESET = 3'h0;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] SYNC_RESET = 2'h3;
    // registers from this address up are not to be used by the master
    localparam logic [6:0] ADDR_UNUSED_FIRST = 7'h78;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_WRITE,
        ST_READ
    } port_state_e;

endpackage

/* verilog/pin_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: one bit, synchronous active-low reset
// Notes: the first flop is read only by the second
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic async_in,
    input wire logic reset_level_in,
    output logic sync_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    // next values: plain shift
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // reset level is a tie-off constant at the instance
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            meta_r <= reset_level_in;
            sync_r <= reset_level_in;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule

/* verilog/serial_register_port.sv */
// Purpose: three-wire serial slave port to 128 byte-wide registers
// Assumes: serial clock well below the 125 MHz system clock
// Notes: serial pins are oversampled; edges found after synchronising
`timescale 1ns/1ps
module serial_register_port
    import serial_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic serial_clk_in,
    input wire logic port_select_low_in,
    input wire logic serial_io_pin_in,
    output logic serial_io_pin_out,
    output logic serial_io_pin_oe_out,
    input wire logic read_edge_select_in,
    output logic [serial_port_pkg::ADDR_W-1:0] reg_addr_out,
    output logic [serial_port_pkg::DATA_W-1:0] reg_wdata_out,
    output logic reg_write_out
);
    import serial_port_pkg::*;

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    logic sclk_s;
    logic csn_s;
    logic sdi_s;

    pin_sync u_sync_sclk (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(serial_clk_in),
        .reset_level_in(1'b0),
        .sync_out(sclk_s)
    );
    pin_sync u_sync_csn (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(port_select_low_in),
        .reset_level_in(1'b1),
        .sync_out(csn_s)
    );
    pin_sync u_sync_sdi (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(serial_io_pin_in),
        .reset_level_in(1'b0),
        .sync_out(sdi_s)
    );

    // ******************************************************************
    // edge detection
    // ******************************************************************
    logic sclk_d_r;
    logic sclk_d_nxt;
    logic rise;
    logic fall;

    assign rise = sclk_s & ~sclk_d_r;
    assign fall = ~sclk_s & sclk_d_r;
    assign sclk_d_nxt = sclk_s;

    // ******************************************************************
    // register storage
    // ******************************************************************
    logic [DATA_W-1:0] regs_r [REG_COUNT];

    // ******************************************************************
    // transfer state
    // ******************************************************************
    port_state_e state_r, state_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] shin_r, shin_nxt;
    logic [DATA_W-1:0] shout_r, shout_nxt;
    logic out_r, out_nxt;
    logic oe_r, oe_nxt;
    logic we_r, we_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [ADDR_W-1:0] waddr_r, waddr_nxt;
    logic launch;
    logic [DATA_W-1:0] byte_in;

    // read data launch edge follows the polarity input
    assign launch = read_edge_select_in ? rise : fall;
    // lsb arrives first so new bits enter from the top
    assign byte_in = {sdi_s, shin_r[DATA_W-1:1]};

    // next-state logic for the whole transfer
    always_comb begin
        state_nxt = state_r;
        bit_nxt = bit_r;
        addr_nxt = addr_r;
        shin_nxt = shin_r;
        shout_nxt = shout_r;
        out_nxt = out_r;
        oe_nxt = oe_r;
        we_nxt = 1'b0;
        wdata_nxt = wdata_r;
        waddr_nxt = waddr_r;
        if (csn_s) begin
            // select high: drop to idle, clear the bit count, release the pin
            state_nxt = ST_IDLE;
            bit_nxt = BIT_RESET;
            oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_CMD;
                    bit_nxt = BIT_RESET;
                    oe_nxt = 1'b0;
                end
                ST_CMD: begin
                    if (rise) begin
                        shin_nxt = byte_in;
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == BIT_LAST) begin
                            // bit 0 direction, bits 7..1 address
                            addr_nxt = byte_in[7:1];
                            if (byte_in[0]) begin
                                state_nxt = ST_READ;
                                oe_nxt = 1'b1;
                                shout_nxt = regs_r[byte_in[7:1]];
                                // first bit goes out at once
                                out_nxt = regs_r[byte_in[7:1]][0];
                            end else begin
                                state_nxt = ST_WRITE;
                            end
                        end
                    end
                end
                ST_WRITE: begin
                    if (rise) begin
                        shin_nxt = byte_in;
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == BIT_LAST) begin
                            we_nxt = 1'b1;
                            wdata_nxt = byte_in;
                            waddr_nxt = addr_r;
                            addr_nxt = addr_r + 7'h01;
                        end
                    end
                end
                ST_READ: begin
                    // count on the sampling edge, launch on chosen edge
                    if (rise) begin
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == BIT_LAST) begin
                            addr_nxt = addr_r + 7'h01;
                            shout_nxt = regs_r[addr_r + 7'h01];
                        end
                    end
                    if (launch) begin
                        // shout_r[0] mirrors the pin bit, except on fall launch between a byte's last rise and the next fall
                        if (read_edge_select_in && bit_r == BIT_LAST)
                        begin
                            out_nxt = regs_r[addr_r + 7'h01][0];
                            shout_nxt = regs_r[addr_r + 7'h01];
                        end else if (!read_edge_select_in && bit_r ==
                                     BIT_RESET) begin
                            // first fall of a byte drives bit 0 from shout_r[0], without a shift
                            out_nxt = shout_r[0];
                        end else begin
                            out_nxt = shout_r[1];
                            shout_nxt = {1'b0, shout_r[7:1]};
                        end
                    end
                end
            endcase
        end
    end

    // register write port; storage updated one cycle after capture
    always_ff @(posedge clk_in) begin
        if (we_r) begin
            regs_r[waddr_r] <= wdata_r;
        end
    end

    // state registers
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= ST_IDLE;
            bit_r <= BIT_RESET;
            addr_r <= ADDR_RESET;
            shin_r <= BYTE_RESET;
            shout_r <= BYTE_RESET;
            out_r <= 1'b0;
            oe_r <= 1'b0;
            we_r <= 1'b0;
            wdata_r <= BYTE_RESET;
            waddr_r <= ADDR_RESET;
            sclk_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            addr_r <= addr_nxt;
            shin_r <= shin_nxt;
            shout_r <= shout_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            we_r <= we_nxt;
            wdata_r <= wdata_nxt;
            waddr_r <= waddr_nxt;
            sclk_d_r <= sclk_d_nxt;
        end
    end

    // outputs from flops; pin enable also gated by the synchronised select
    assign serial_io_pin_out = out_r;
    assign serial_io_pin_oe_out = oe_r & ~csn_s;
    assign reg_addr_out = waddr_r;
    assign reg_wdata_out = wdata_r;
    assign reg_write_out = we_r;
endmodule

/* tb/serial_port_asserts.sv */
// Purpose: port checks for serial_register_port
// Assumes: serial clock well below clk_in
// Notes: one sampling flop keeps this view ahead of the port
`timescale 1ns/1ps
module serial_port_asserts (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic serial_clk_in,
    input wire logic port_select_low_in,
    input wire logic serial_io_pin_out,
    input wire logic serial_io_pin_oe_out,
    input wire logic read_edge_select_in,
    input wire logic [6:0] reg_addr_out,
    input wire logic reg_write_out
);
    logic [1:0] s_r;
    logic [5:0] rcnt_r;
    logic [2:0] lage_r;
    logic [6:0] last_r;
    logic cont_r;
    wire rise = s_r[0] & ~s_r[1];
    wire launch = read_edge_select_in ? rise : (~s_r[0] & s_r[1]);
    // rises per frame, cycles since launch edge, last written address
    always_ff @(posedge clk_in) begin
        s_r <= {s_r[0], serial_clk_in};
        if (!resetn_in || port_select_low_in) rcnt_r <= 6'h00;
        else if (rise) rcnt_r <= rcnt_r + 6'h01;
        if (launch) lage_r <= 3'h0;
        else if (lage_r != 3'h7) lage_r <= lage_r + 3'h1;
        if (!resetn_in || port_select_low_in) cont_r <= 1'b0;
        else if (reg_write_out) cont_r <= 1'b1;
        if (reg_write_out) last_r <= reg_addr_out;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_idle_released: assert property (port_select_low_in[*5]
        |-> !serial_io_pin_oe_out) else $error("pin driven unselected");
    a_idle_no_write: assert property (port_select_low_in[*8]
        |-> !reg_write_out) else $error("write while unselected");
    a_read_turn: assert property ($rose(serial_io_pin_oe_out)
        |-> rcnt_r == 6'h08) else $error("pin turned at wrong bit");
    a_write_bytes: assert property (reg_write_out
        |-> rcnt_r[2:0] == 3'h0 && rcnt_r >= 6'h10)
        else $error("write not on byte end");
    a_write_pulse: assert property (reg_write_out |=> !reg_write_out)
        else $error("write strobe too long");
    a_read_no_write: assert property (serial_io_pin_oe_out
        |-> !reg_write_out) else $error("write during read");
    a_addr_step: assert property (reg_write_out && cont_r
        |-> reg_addr_out == last_r + 7'h01) else $error("address step");
    a_launch_edge: assert property (serial_io_pin_oe_out
        && $past(serial_io_pin_oe_out) && rcnt_r > 6'h08
        && serial_io_pin_out != $past(serial_io_pin_out)
        |-> lage_r <= 3'h4) else $error("read bit on wrong edge");
    c_write: cover property (reg_write_out && cont_r);
    c_read_fall: cover property ($rose(serial_io_pin_oe_out)
        && !read_edge_select_in);
    c_read_rise: cover property ($rose(serial_io_pin_oe_out)
        && read_edge_select_in);
endmodule
bind serial_register_port serial_port_asserts chk (.clk_in(clk_in),
    .resetn_in(resetn_in), .serial_clk_in(serial_clk_in),
    .port_select_low_in(port_select_low_in),
    .serial_io_pin_out(serial_io_pin_out),
    .serial_io_pin_oe_out(serial_io_pin_oe_out),
    .read_edge_select_in(read_edge_select_in),
    .reg_addr_out(reg_addr_out), .reg_write_out(reg_write_out));

/* tb/serial_master.sv */
// Purpose: serial master facing the register port
// Assumes: 8 clk_in cycles per serial bit (64 ns)
// Notes: serial clock stands low between frames
`timescale 1ns/1ps
module serial_master (
    input wire logic clk_in,
    input wire logic edge_in,
    input wire logic io_in,
    output logic sclk_out,
    output logic sel_low_out,
    output logic dat_out,
    output logic drv_out
);
    logic [7:0] wbuf[4];
    logic [7:0] rbuf[4];
    initial begin
        sclk_out = 1'b0;
        sel_low_out = 1'b1;
        dat_out = 1'b0;
        drv_out = 1'b0;
    end
    // data set in the low half, read just before its launch edge
    task automatic bitc(input logic b, output logic r);
        sclk_out <= 1'b0;
        dat_out <= b;
        repeat (4) @(posedge clk_in);
        if (edge_in) r = io_in;
        sclk_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        if (!edge_in) r = io_in;
    endtask
    // nc command bits, then n bytes; reads release the line
    task automatic frame(input logic rd, input logic [6:0] a,
        input int n, input int nc, input logic live);
        logic [7:0] cmd;
        logic r;
        cmd = {a, rd};
        sel_low_out <= ~live;
        drv_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < nc; i++) bitc(cmd[i], r);
        drv_out <= !rd;
        for (int k = 0; k < n; k++)
            for (int i = 0; i < 8; i++) begin
                bitc(wbuf[k][i], r);
                rbuf[k][i] = r;
            end
        sclk_out <= 1'b0;
        repeat (8) @(posedge clk_in);
        sel_low_out <= 1'b1;
        drv_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

/* tb/serial_register_port_bench.sv */
// Purpose: self-checking bench for serial_register_port
// Assumes: 125 MHz clk_in, 64 ns serial clock
// Notes: undriven data line toggles every cycle
`timescale 1ns/1ps
module serial_register_port_bench;
    import serial_port_pkg::*;
    logic clk_in, resetn_in, edge_sel, flt;
    logic sclk, sel_low, mdat, mdrv, pout, poe, wr;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [14:0] seen[$];
    int bad_count;
    int comparisons;
    wire io = poe ? pout : (mdrv ? mdat : flt);
    serial_register_port DUT (.clk_in(clk_in), .resetn_in(resetn_in),
        .serial_clk_in(sclk), .port_select_low_in(sel_low),
        .serial_io_pin_in(io), .serial_io_pin_out(pout),
        .serial_io_pin_oe_out(poe), .read_edge_select_in(edge_sel),
        .reg_addr_out(waddr), .reg_wdata_out(wdata), .reg_write_out(wr));
    serial_master m (.clk_in(clk_in), .edge_in(edge_sel), .io_in(io),
        .sclk_out(sclk), .sel_low_out(sel_low), .dat_out(mdat),
        .drv_out(mdrv));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // floating line and store log
    always @(posedge clk_in) begin
        flt <= ~flt;
        if (wr === 1'b1) seen.push_back({waddr, wdata});
    end
    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic t_write;
        m.wbuf = '{8'ha5, 8'h3c, 8'h01, 8'h77};
        m.frame(1'b0, 7'h05, 3, 8, 1'b1);
        check(15'(seen.size()), 15'h3);
        for (int k = 0; k < 3; k++)
            check(seen.pop_front(), {7'(5 + k), m.wbuf[k]});
        $display("write test done");
    endtask
    task automatic t_read(input logic e, input logic [6:0] a, input int n);
        edge_sel <= e;
        @(posedge clk_in);
        m.frame(1'b1, a, n, 8, 1'b1);
        for (int k = 0; k < n; k++)
            check(15'(m.rbuf[k]), 15'(m.wbuf[a - 5 + k]));
        check(15'(seen.size()), 15'h0);
        $display("read test done");
    endtask
    // activity while deselected, then a cut command
    task automatic t_idle;
        m.frame(1'b0, 7'h05, 2, 8, 1'b0);
        check(15'(seen.size()), 15'h0);
        m.frame(1'b1, 7'h05, 0, 3, 1'b1);
        t_read(1'b0, 7'h05, 1);
        $display("idle test done");
    endtask
    task automatic stop_test;
        $display("counts %0d bad %0d compared", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        resetn_in = 1'b0;
        edge_sel = 1'b0;
        flt = 1'b0;
        bad_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        t_write();
        t_read(1'b0, 7'h05, 3);
        t_read(1'b1, 7'h06, 2);
        t_idle();
        stop_test();
    end
    // watchdog: about six times the expected run
    initial begin
        #60000;
        bad_count++;
        stop_test();
    end
endmodule
